//--- core/carrier_divider.sv
// Square-wave generator: toggles its output every half_count clocks.
// Assumes half_count is at least 1; a change restarts the half period.
`timescale 1ns/1ps

module carrier_divider #(
  parameter int HALF_W = 11
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              reset,
  // Control
  input  wire logic              run,
  input  wire logic [HALF_W-1:0] half_count,
  // Carrier
  output logic                   wave
);

  logic [HALF_W-1:0] cnt_q;    // Cycles left in this half period
  logic [HALF_W-1:0] last_q;   // Count in force, to spot reprogramming

  ////////////////////////////////////////////////////////////////////////////
  // Half-period counter; a new count restarts cleanly, so no runt pulse
  always_ff @(posedge mclk)
  begin
    if (reset || !run)
    begin
      cnt_q  <= '0;
      last_q <= '0;
      wave   <= 1'b0;
    end
    else if (half_count != last_q)
    begin
      // Reprogrammed: restart the half period at the new length
      last_q <= half_count;
      cnt_q  <= half_count - 1'b1;
    end
    else if (cnt_q == '0)
    begin
      // Half period done: flip and reload
      cnt_q <= half_count - 1'b1;
      wave  <= ~wave;
    end
    else
    begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

endmodule // carrier_divider

//--- core/ext_switch_mux.sv
// Extension switch decode: routes each external impedance input onto one
// ECG converter channel. Assumes analog switches driven by these selects.
`timescale 1ns/1ps

module ext_switch_mux #(
  parameter int NUM_SW = 3,
  parameter int NUM_CH = 5
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              reset,
  // Switch settings
  input  wire logic [NUM_SW-1:0] extension_switches,
  // Channel routing
  output logic [NUM_CH-1:0]      ch_from_external,
  output logic [3:0]             electrode_count
);

  logic [NUM_CH-1:0] route_d;   // Next channel routing
  logic [3:0]        count_d;   // Next electrode total

  ////////////////////////////////////////////////////////////////////////////
  // Switch n takes external input n onto channel n; others keep electrodes
  always_comb
  begin
    route_d = '0;
    count_d = resp_carrier_pkg::BASE_ELECTRODES;
    for (int i = 0; i < NUM_SW; i++)
    begin
      route_d[i] = extension_switches[i];
      count_d    = count_d + {3'h0, extension_switches[i]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered selects so the analog switches see clean levels
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ch_from_external <= '0;
      electrode_count  <= resp_carrier_pkg::BASE_ELECTRODES;
    end
    else
    begin
      ch_from_external <= route_d;
      electrode_count  <= count_d;
    end
  end

endmodule // ext_switch_mux

//--- core/resp_carrier_freq_select.sv
// Respiration carrier frequency selection, carrier sync pin and
// external impedance input extension switches.
// Assumes one 50 MHz clock, synchronous reset and a simple register port
// with read data one cycle after the read strobe.
//
// Contract
// - Alt off: codes give 56/54/52/50 kHz.
// - Alt, high perf, no sync: 64/56.9/51.2/46.5 kHz.
// - Alt, low power: 32/28/25.5/23 kHz always.
// - Sync select drives carrier sync on pin.
// - Sync pin frequency follows the sync table.
// - External inputs can feed ECG channels.
// - Only one respiration path at once.
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module resp_carrier_freq_select #(
  parameter int ADDR_W = resp_carrier_pkg::ADDR_W,
  parameter int DATA_W = resp_carrier_pkg::DATA_W,
  parameter int NUM_SW = resp_carrier_pkg::NUM_SW,
  parameter int NUM_CH = resp_carrier_pkg::NUM_CH
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              reset,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [DATA_W-1:0]      reg_rdata,
  // Respiration excitation
  output logic                   resp_carrier,
  output logic [3:0]             resp_path_sel,
  // Carrier sync pin
  output logic                   sync_output_pin_out,
  output logic                   sync_output_pin_oe,
  // Extension switch routing
  output logic [NUM_CH-1:0]      ch_from_external,
  output logic [3:0]             electrode_count
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [DATA_W-1:0] respiration_control_reg_q;  // Respiration control
  logic [DATA_W-1:0] acquisition_control_reg_q;  // Acquisition control
  logic [NUM_SW-1:0] ext_sw_q;                   // Extension switches
  logic [DATA_W-1:0] rdata_d;                    // Read mux result

  // Decoded control fields
  logic              resp_enable;                // Respiration running
  logic [1:0]        carrier_freq_code;          // Carrier frequency code
  logic              alt_freq_select;            // Alternate frequency set
  logic              carrier_sync_enable;        // External sync mode
  logic [1:0]        path_code;                  // Measurement path code
  logic              sync_output_select;         // Sync onto the pin
  logic              high_perf_mode;             // High performance mode

  // Divider controls
  logic [resp_carrier_pkg::HALF_W-1:0] carrier_half;  // Carrier half period
  logic [resp_carrier_pkg::HALF_W-1:0] sync_half;     // Sync half period
  logic              sync_wave;                  // Sync divider output

  ////////////////////////////////////////////////////////////////////////////
  // Field extraction
  assign resp_enable         = respiration_control_reg_q[resp_carrier_pkg::RESP_EN_BIT];
  assign carrier_freq_code   = respiration_control_reg_q[resp_carrier_pkg::FREQ_CODE_LSB +: 2];
  assign alt_freq_select     = respiration_control_reg_q[resp_carrier_pkg::ALT_FREQ_BIT];
  assign carrier_sync_enable = respiration_control_reg_q[resp_carrier_pkg::SYNC_EN_BIT];
  assign path_code           = respiration_control_reg_q[resp_carrier_pkg::PATH_SEL_LSB +: 2];
  assign sync_output_select  = respiration_control_reg_q[resp_carrier_pkg::SYNC_OUT_SEL_BIT];
  assign high_perf_mode      = acquisition_control_reg_q[resp_carrier_pkg::HIGH_PERF_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Standard table: alternate select off
  function automatic logic [10:0] std_half(input logic [1:0] code);
    case (code)
      2'h0:    std_half = resp_carrier_pkg::H_56K;
      2'h1:    std_half = resp_carrier_pkg::H_54K;
      2'h2:    std_half = resp_carrier_pkg::H_52K;
      default: std_half = resp_carrier_pkg::H_50K;
    endcase
  endfunction

  // Alternate table; only code 01 in high performance differs with sync on
  function automatic logic [10:0] alt_half(input logic [1:0] code,
                                           input logic       hp,
                                           input logic       sync);
    if (hp)
    begin
      case (code)
        2'h0:    alt_half = resp_carrier_pkg::H_64K;
        2'h1:    alt_half = sync ? resp_carrier_pkg::H_56K : resp_carrier_pkg::H_56K9;
        2'h2:    alt_half = resp_carrier_pkg::H_51K2;
        default: alt_half = resp_carrier_pkg::H_46K5;
      endcase
    end
    else
    begin
      case (code)
        2'h0:    alt_half = resp_carrier_pkg::H_32K;
        2'h1:    alt_half = resp_carrier_pkg::H_28K;
        2'h2:    alt_half = resp_carrier_pkg::H_25K5;
        default: alt_half = resp_carrier_pkg::H_23K;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Carrier frequency selection
  // The code only picks a divider count; the divider restarts on any
  // change, so a retune costs at most one stretched half period.
  always_comb
  begin
    if (!alt_freq_select)
    begin
      // Standard codes hold whatever the performance mode
      carrier_half = std_half(carrier_freq_code);
    end
    else if (high_perf_mode)
    begin
      // With sync on, the carrier follows the pin so the generator locks
      carrier_half = alt_half(carrier_freq_code, 1'b1, carrier_sync_enable);
    end
    else
    begin
      // Low power ignores the sync setting
      carrier_half = alt_half(carrier_freq_code, 1'b0, 1'b0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sync pin frequency selection
  // Limitation: pin and carrier come from separate dividers, so their
  // phase relation is not fixed, only their rates.
  always_comb
  begin
    if (!carrier_sync_enable)
    begin
      // Without external sync the pin mirrors the internal carrier
      sync_half = carrier_half;
    end
    else if (!alt_freq_select)
    begin
      sync_half = resp_carrier_pkg::H_64K;
    end
    else
    begin
      sync_half = alt_half(carrier_freq_code, high_perf_mode, 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Carrier and sync dividers
  carrier_divider #(
    .HALF_W     (resp_carrier_pkg::HALF_W)
  ) u_carrier_div (
    .mclk       (mclk),
    .reset      (reset),
    .run        (resp_enable),
    .half_count (carrier_half),
    .wave       (resp_carrier)
  );

  // Separate divider: the pin rate may differ from the carrier rate
  carrier_divider #(
    .HALF_W     (resp_carrier_pkg::HALF_W)
  ) u_sync_div (
    .mclk       (mclk),
    .reset      (reset),
    .run        (sync_output_select),
    .half_count (sync_half),
    .wave       (sync_wave)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sync pin drive, registered to keep the pin free of decode glitches
  // Enable and level share one register stage, so the pin never shows
  // a level from before it was enabled.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      sync_output_pin_out <= 1'b0;
      sync_output_pin_oe  <= 1'b0;
    end
    else
    begin
      sync_output_pin_out <= sync_output_select & sync_wave;
      sync_output_pin_oe  <= sync_output_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Measurement path: one-hot, so only one pair is ever excited
  // The two-bit code can name only one path, so no write, however
  // malformed, can excite a second pair.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      resp_path_sel <= 4'h0;
    end
    else if (resp_enable)
    begin
      resp_path_sel <= 4'h1 << path_code;
    end
    else
    begin
      resp_path_sel <= 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; unmapped addresses are ignored
  // Control words are stored whole, so spare bits read back as written
  // and software read-modify-write stays simple.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      respiration_control_reg_q <= resp_carrier_pkg::RESP_CTRL_RESET;
      acquisition_control_reg_q <= resp_carrier_pkg::ACQ_CTRL_RESET;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        resp_carrier_pkg::RESP_CTRL_ADDR:
          respiration_control_reg_q <= reg_wdata;
        resp_carrier_pkg::ACQ_CTRL_ADDR:
          acquisition_control_reg_q <= reg_wdata;
        default:
          ;
      endcase
    end
  end

  // Switch settings; routed data settles only after the host's wait
  // The host, not this block, times that wait; nothing here holds the
  // rerouted channel data back.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ext_sw_q <= resp_carrier_pkg::EXT_SW_RESET;
    end
    else if (reg_wr && reg_addr == resp_carrier_pkg::EXT_SW_ADDR)
    begin
      ext_sw_q <= reg_wdata[NUM_SW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_d = '0;
    case (reg_addr)
      resp_carrier_pkg::RESP_CTRL_ADDR:
        rdata_d = respiration_control_reg_q;
      resp_carrier_pkg::ACQ_CTRL_ADDR:
        rdata_d = acquisition_control_reg_q;
      resp_carrier_pkg::EXT_SW_ADDR:
        rdata_d[NUM_SW-1:0] = ext_sw_q;
      resp_carrier_pkg::CARRIER_STAT_ADDR:
        rdata_d[10:0] = carrier_half;
      default:
        rdata_d = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  // Zero outside that cycle, so a master that samples late sees an
  // obvious empty word rather than a stale value.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      reg_rdata <= '0;
    end
    else if (reg_rd)
    begin
      reg_rdata <= rdata_d;
    end
    else
    begin
      reg_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Extension switch routing
  ext_switch_mux #(
    .NUM_SW             (NUM_SW),
    .NUM_CH             (NUM_CH)
  ) u_ext_mux (
    .mclk               (mclk),
    .reset              (reset),
    .extension_switches (ext_sw_q),
    .ch_from_external   (ch_from_external),
    .electrode_count    (electrode_count)
  );

endmodule // resp_carrier_freq_select

//--- core/resp_carrier_pkg.sv
// Constants for the respiration carrier selector: register map, field
// positions, reset values and carrier divider counts.
// Assumes a single 50 MHz system clock and a 16-bit register port.
package resp_carrier_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register port geometry
  localparam int          ADDR_W              = 8;
  localparam int          DATA_W              = 16;

  // Register offsets
  localparam logic [7:0]  ACQ_CTRL_ADDR       = 8'h01;  // Acquisition control
  localparam logic [7:0]  RESP_CTRL_ADDR      = 8'h03;  // Respiration control
  localparam logic [7:0]  EXT_SW_ADDR         = 8'h0A;  // Extension switches
  localparam logic [7:0]  CARRIER_STAT_ADDR   = 8'h0B;  // Carrier status, read only

  // Respiration control fields
  localparam int          RESP_EN_BIT         = 0;
  localparam int          FREQ_CODE_LSB       = 1;      // Two bits: 2..1
  localparam int          ALT_FREQ_BIT        = 3;
  localparam int          SYNC_EN_BIT         = 4;
  localparam int          PATH_SEL_LSB        = 5;      // Two bits: 6..5
  localparam int          SYNC_OUT_SEL_BIT    = 7;

  // Acquisition control fields
  localparam int          HIGH_PERF_BIT       = 3;

  // Reset values
  localparam logic [15:0] RESP_CTRL_RESET     = 16'h0000;
  localparam logic [15:0] ACQ_CTRL_RESET      = 16'h0008;  // High performance on
  localparam logic [2:0]  EXT_SW_RESET        = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier frequencies in Hz
  localparam int          CLK_HZ              = 50_000_000;
  localparam int          F_64K               = 64_000;
  localparam int          F_56K               = 56_000;
  localparam int          F_54K               = 54_000;
  localparam int          F_52K               = 52_000;
  localparam int          F_50K               = 50_000;
  localparam int          F_56K9              = 56_900;
  localparam int          F_51K2              = 51_200;
  localparam int          F_46K5              = 46_500;
  localparam int          F_32K               = 32_000;
  localparam int          F_28K               = 28_000;
  localparam int          F_25K5              = 25_500;
  localparam int          F_23K               = 23_000;

  // Half-period counts, rounded to nearest cycle
  localparam int          HALF_W              = 11;
  localparam logic [10:0] H_64K  = 11'((CLK_HZ + F_64K)  / (2 * F_64K));
  localparam logic [10:0] H_56K  = 11'((CLK_HZ + F_56K)  / (2 * F_56K));
  localparam logic [10:0] H_54K  = 11'((CLK_HZ + F_54K)  / (2 * F_54K));
  localparam logic [10:0] H_52K  = 11'((CLK_HZ + F_52K)  / (2 * F_52K));
  localparam logic [10:0] H_50K  = 11'((CLK_HZ + F_50K)  / (2 * F_50K));
  localparam logic [10:0] H_56K9 = 11'((CLK_HZ + F_56K9) / (2 * F_56K9));
  localparam logic [10:0] H_51K2 = 11'((CLK_HZ + F_51K2) / (2 * F_51K2));
  localparam logic [10:0] H_46K5 = 11'((CLK_HZ + F_46K5) / (2 * F_46K5));
  localparam logic [10:0] H_32K  = 11'((CLK_HZ + F_32K)  / (2 * F_32K));
  localparam logic [10:0] H_28K  = 11'((CLK_HZ + F_28K)  / (2 * F_28K));
  localparam logic [10:0] H_25K5 = 11'((CLK_HZ + F_25K5) / (2 * F_25K5));
  localparam logic [10:0] H_23K  = 11'((CLK_HZ + F_23K)  / (2 * F_23K));

  ////////////////////////////////////////////////////////////////////////////
  // Extension switches and respiration paths
  localparam int          NUM_SW              = 3;
  localparam int          NUM_CH              = 5;
  localparam logic [3:0]  BASE_ELECTRODES     = 4'h5;
  localparam int          NUM_PATHS           = 4;      // Lead I, II, III, external

endpackage

//--- testbench/carrier_sync_follower.sv
// External carrier generator model: locks to the sync pin and reports
// the half period it sees. Assumes the pin is sampled on mclk.
`timescale 1ns/1ps

module carrier_sync_follower (
  // Clock
  input wire logic mclk,
  // Sync pin seen from outside
  input wire logic pin_level,
  input wire logic pin_driven,
  // Lock status
  output int       half_seen,
  output int       edges_seen
);
  logic last_q = 1'b0;  // Pin level at previous edge
  int   cnt_q  = 0;     // Cycles since last pin edge
  initial half_seen = 0;
  initial edges_seen = 0;

  // Measure edge spacing; a released pin gives nothing to lock to
  always @(posedge mclk)
  begin
    last_q <= pin_level;
    if (!pin_driven)
      cnt_q <= 0;
    else if (pin_level !== last_q)
    begin
      half_seen  <= cnt_q + 1;
      edges_seen <= edges_seen + 1;
      cnt_q      <= 0;
    end
    else
      cnt_q <= cnt_q + 1;
  end
endmodule // carrier_sync_follower

//--- testbench/resp_carrier_freq_select_bench.sv
// Self-checking bench for the carrier selector: register tasks, carrier and
// sync pin rates, path select and switch routing. One 50 MHz clock.
`timescale 1ns/1ps

module resp_carrier_freq_select_bench;
  logic        mclk = 1'b0;       // System clock
  logic        reset = 1'b1;      // Synchronous reset
  logic [7:0]  reg_addr = 8'h00;  // Register port
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic        resp_carrier;
  logic [3:0]  resp_path_sel;
  logic        sync_output_pin_out;
  logic        sync_output_pin_oe;
  logic [4:0]  ch_from_external;
  logic [3:0]  electrode_count;
  int          half_seen;         // From the follower
  int          edges_seen;
  int          err_count = 0;
  int          n_checks = 0;
  // Carrier frequencies in 100 Hz units, per mode row and code
  int car_f [3][4] = '{'{560, 540, 520, 500}, '{640, 569, 512, 465}, '{320, 280, 255, 230}};
  int pin_f [3][4] = '{'{640, 640, 640, 640}, '{640, 560, 512, 465}, '{320, 280, 255, 230}};

  always #10 mclk = ~mclk;

  resp_carrier_freq_select dut (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .resp_carrier(resp_carrier),
    .resp_path_sel(resp_path_sel), .sync_output_pin_out(sync_output_pin_out),
    .sync_output_pin_oe(sync_output_pin_oe), .ch_from_external(ch_from_external),
    .electrode_count(electrode_count)
  );
  carrier_sync_follower gen (
    .mclk(mclk), .pin_level(sync_output_pin_out), .pin_driven(sync_output_pin_oe),
    .half_seen(half_seen), .edges_seen(edges_seen)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Expected half period, rounded to nearest clock
  function automatic int half_of(input int f100);
    return (resp_carrier_pkg::CLK_HZ + f100 * 100) / (f100 * 200);
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Third carrier interval: the first may be stretched by a restart
  task automatic meas_carrier(output int h);
    int n, k, c;
    logic last;
    h = 0; c = 0; k = 0; last = resp_carrier;
    for (n = 0; n < 4000 && k < 3; n++)
    begin
      @(posedge mclk);
      c++;
      if (resp_carrier !== last)
      begin
        last = resp_carrier; h = c; c = 0; k++;
      end
    end
  endtask

  // Let the follower see three pin edges, then take its lock
  task automatic meas_pin(output int h);
    int n, e;
    e = edges_seen;
    for (n = 0; n < 4000 && edges_seen < e + 3; n++)
      @(posedge mclk);
    h = half_seen;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: tests need about 50k cycles
  initial
  begin
    #(20 * 90_000);
    err_count++;
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    logic [15:0] d;
    int m, c, h, perf, alt, row;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    rd_reg(8'h01, d); check(d, 16'h0008, "acq ctrl reset");
    @(posedge mclk);
    #1 check(reg_rdata, 0, "read data cleared");
    rd_reg(8'h03, d); check(d, 16'h0000, "resp ctrl reset");
    rd_reg(8'h55, d); check(d, 16'h0000, "unmapped read");
    $display("test reset values done");
    for (m = 0; m < 4; m++)
      for (c = 0; c < 4; c++)
      begin
        perf = (m == 0 || m == 2); alt = (m >= 2); row = (m < 2) ? 0 : m - 1;
        wr_reg(8'h01, 16'(perf * 8));
        wr_reg(8'h03, 16'(1 + c * 2 + alt * 8 + (m == 3) * 16));
        meas_carrier(h);
        check(h, half_of(car_f[row][c]), "carrier half");
        rd_reg(8'h0B, d); check(d, half_of(car_f[row][c]), "status half");
      end
    $display("test carrier table done");
    for (m = 0; m < 3; m++)
      for (c = 0; c < 4; c++)
      begin
        wr_reg(8'h01, 16'((m < 2) * 8));
        wr_reg(8'h03, 16'(1 + c * 2 + (m > 0) * 8 + 16 + 128));
        meas_pin(h);
        check(h, half_of(pin_f[m][c]), "sync pin half");
        check(sync_output_pin_oe, 1, "pin driven");
      end
    wr_reg(8'h03, 16'h0000);
    repeat (3) @(posedge mclk);
    check({sync_output_pin_oe, sync_output_pin_out}, 0, "pin released");
    $display("test sync pin done");
    for (m = 0; m < 4; m++)
    begin
      wr_reg(8'h03, 16'(1 + m * 32));
      repeat (3) @(posedge mclk);
      check(resp_path_sel, 1 << m, "path select");
    end
    for (m = 0; m < 8; m++)
    begin
      wr_reg(8'h0A, 16'(m));
      repeat (3) @(posedge mclk);
      check(ch_from_external, m, "switch routing");
      check(electrode_count, 5 + $countones(m[2:0]), "electrode count");
      rd_reg(8'h0A, d); check(d, m, "switch readback");
    end
    $display("test paths and switches done");
    tally_and_finish();
  end
endmodule // resp_carrier_freq_select_bench

//--- testbench/resp_carrier_freq_select_checker.sv
// Concurrent checks on the carrier selector top, bound to its ports.
// Assumes one clock mclk and a synchronous active-high reset.
`timescale 1ns/1ps

module resp_carrier_freq_select_checker #(
  parameter int ADDR_W = 8,
  parameter int NUM_CH = 5
) (
  // Clock and reset
  input wire logic              mclk,
  input wire logic              reset,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic              reg_wr,
  // Watched outputs
  input wire logic              resp_carrier,
  input wire logic [3:0]        resp_path_sel,
  input wire logic              sync_output_pin_out,
  input wire logic              sync_output_pin_oe,
  input wire logic [NUM_CH-1:0] ch_from_external,
  input wire logic [3:0]        electrode_count
);
  localparam int MIN_HALF = 390;   // Fastest half period 391; gap_q reads one less
  localparam int MAX_HALF = 1100;  // Slowest is 1087, slack for restart
  logic        cfg_wr;             // Write that may retune a divider
  logic        resp_wr;            // Write to respiration control
  logic [11:0] car_cnt_q;          // Cycles since carrier edge
  logic [11:0] pin_cnt_q;          // Cycles since pin edge
  logic [11:0] gap_q;              // Cycles since carrier edge, writes ignored
  assign resp_wr = reg_wr && reg_addr == resp_carrier_pkg::RESP_CTRL_ADDR;
  assign cfg_wr  = resp_wr || (reg_wr && reg_addr == resp_carrier_pkg::ACQ_CTRL_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Edge spacing counters; a retune restarts them so restarts never fire
  always_ff @(posedge mclk)
  begin
    if (reset || cfg_wr || $changed(resp_carrier))
      car_cnt_q <= 12'h000;
    else if (car_cnt_q != 12'hFFF)
      car_cnt_q <= car_cnt_q + 12'h001;
  end

  // Pin counter also idles while the pin is released
  always_ff @(posedge mclk)
  begin
    if (reset || cfg_wr || !sync_output_pin_oe || $changed(sync_output_pin_out))
      pin_cnt_q <= 12'h000;
    else if (pin_cnt_q != 12'hFFF)
      pin_cnt_q <= pin_cnt_q + 12'h001;
  end

  // Edge gap not cleared by writes: a write that does not retune the
  // divider leaves its phase alone, so the gap must span it
  always_ff @(posedge mclk)
  begin
    if (reset || $changed(resp_carrier))
      gap_q <= 12'h000;
    else if (gap_q != 12'hFFF)
      gap_q <= gap_q + 12'h001;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  path_one_hot_a:
    assert property ($onehot0(resp_path_sel)) else $error("several respiration paths at once");
  pin_quiet_a:
    assert property (!sync_output_pin_oe && !$past(sync_output_pin_oe) |-> !sync_output_pin_out)
    else $error("sync pin moves while released");
  pin_enable_cause_a:
    assert property ($changed(sync_output_pin_oe) |-> $past(resp_wr) || $past(resp_wr, 2) || $past(reset))
    else $error("pin enable changed with no control write");
  count_match_a:
    assert property (electrode_count == 4'h5 + 4'($countones(ch_from_external)))
    else $error("electrode count disagrees with routing");
  upper_ch_idle_a:
    assert property (ch_from_external[NUM_CH-1:3] == '0) else $error("unswitched channel rerouted");
  carrier_slow_a:
    assert property (resp_path_sel != 4'h0 |-> car_cnt_q < MAX_HALF) else $error("carrier stalled");
  carrier_fast_a:
    assert property ($changed(resp_carrier) && resp_path_sel != 4'h0 && $past(resp_path_sel) != 4'h0
                     |-> gap_q >= MIN_HALF)
    else $error("carrier edge too early");
  pin_rate_a:
    assert property (sync_output_pin_oe && $past(sync_output_pin_oe) |-> pin_cnt_q < MAX_HALF)
    else $error("sync pin stalled");
  reset_state_a:
    assert property ($fell(reset) |-> electrode_count == 4'h5 && resp_path_sel == 4'h0 && !sync_output_pin_oe)
    else $error("outputs not at reset values");
endmodule // resp_carrier_freq_select_checker

bind resp_carrier_freq_select resp_carrier_freq_select_checker #(
  .ADDR_W(ADDR_W),
  .NUM_CH(NUM_CH)
) chk (
  .mclk(mclk),
  .reset(reset),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .resp_carrier(resp_carrier),
  .resp_path_sel(resp_path_sel),
  .sync_output_pin_out(sync_output_pin_out),
  .sync_output_pin_oe(sync_output_pin_oe),
  .ch_from_external(ch_from_external),
  .electrode_count(electrode_count)
);
